// ### rtl/clkout_pkg.sv
package clkout_pkg;

  // wishbone widths
  localparam int          ADR_W       = 8;
  localparam int          DAT_W       = 32;
  localparam int          IDX_W       = 6;

  // register indices, byte address is four times the index
  localparam logic [5:0]  IDX_DIV01   = 6'h21;
  localparam logic [5:0]  IDX_CTL2    = 6'h22;
  localparam logic [5:0]  IDX_CTL3    = 6'h23;
  localparam logic [5:0]  IDX_DIV23   = 6'h24;

  // reset values
  localparam logic [7:0]  RST_DIV01   = 8'h01;
  localparam logic [7:0]  RST_DIV23   = 8'h03;
  localparam logic        RST_SRC23   = 1'h1;
  localparam logic [1:0]  RST_FMT     = 2'h1;
  localparam logic [1:0]  RST_MODE_A  = 2'h2;
  localparam logic [1:0]  RST_MODE_B  = 2'h0;

  // field positions inside the control registers
  localparam int          SRC_BIT     = 7;
  localparam int          FMT_HI      = 6;
  localparam int          FMT_LO      = 5;
  localparam int          MA_HI       = 4;
  localparam int          MA_LO       = 3;
  localparam int          MB_HI       = 2;
  localparam int          MB_LO       = 1;

  // driver format codes
  localparam logic [1:0]  FMT_OFF     = 2'h0;
  localparam logic [1:0]  FMT_ACDIFF  = 2'h1;
  localparam logic [1:0]  FMT_HCSL    = 2'h2;
  localparam logic [1:0]  FMT_LVCMOS  = 2'h3;

  // single-ended pin modes
  localparam logic [1:0]  PIN_TRI     = 2'h0;
  localparam logic [1:0]  PIN_LOW     = 2'h1;
  localparam logic [1:0]  PIN_INV     = 2'h2;
  localparam logic [1:0]  PIN_TRUE    = 2'h3;

  // tail current in mA
  localparam logic [4:0]  TAIL_4MA    = 5'h04;
  localparam logic [4:0]  TAIL_6MA    = 5'h06;
  localparam logic [4:0]  TAIL_8MA    = 5'h08;
  localparam logic [4:0]  TAIL_16MA   = 5'h10;

  // hcsl load in ohm, zero means tristated load
  localparam logic [7:0]  LOAD_TRI    = 8'h00;
  localparam logic [7:0]  LOAD_50     = 8'h32;
  localparam logic [7:0]  LOAD_100    = 8'h64;
  localparam logic [7:0]  LOAD_200    = 8'hc8;

  // driven state of one output channel
  typedef struct packed {
    logic       p;
    logic       p_oe;
    logic       n;
    logic       n_oe;
    logic [4:0] tail_ma;
    logic [7:0] load_ohm;
  } drv_t;

endpackage

// ### rtl/clk_out_divider.sv
`timescale 1ns/1ps

module clk_out_divider
  import clkout_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       src_level,
  input  wire logic [7:0] div_field,
  output logic            div_clk
);

  typedef struct packed {
    logic       prev;
    logic [7:0] cnt;
    logic       out;
  } div_state_t;

  div_state_t q;
  div_state_t d;
  logic       rise;
  logic [8:0] half;

  // count source rising edges, wrap after field plus one of them
  always_comb begin
    d    = q;
    rise = src_level & ~q.prev;
    half = 9'((9'(div_field) + 9'h001) >> 1);
    d.prev = src_level;
    if (rise) begin
      if (q.cnt >= div_field) begin // [R2]
        d.cnt = 8'h00;
      end else begin
        d.cnt = q.cnt + 8'h01;
      end
    end
    // divide by one passes the source straight through
    if (div_field == 8'h00) begin // [R2]
      d.out = src_level;
    end else begin
      d.out = (9'(d.cnt) < half);
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign div_clk = q.out;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_CNT_WRAP: assert property (ce && rise && q.cnt >= div_field |=> q.cnt == 8'h00) // [R2]
    else $error("divider count did not wrap");
  AST_CNT_STEP: assert property ( // [R2]
    ce && rise && q.cnt < div_field |=> q.cnt == $past(q.cnt) + 8'h01)
    else $error("divider count did not advance");
  AST_BYPASS: assert property (ce && div_field == 8'h00 |=> div_clk == $past(src_level)) // [R2]
    else $error("divide by one does not follow source");

endmodule // clk_out_divider

// ### rtl/clkout_cfg.sv
`timescale 1ns/1ps

// Summary of operation
// R1 - Channels 0 and 1 share one 8-bit divider whose field resets to 0x01.
// R2 - Every output divider divides by its field value plus one, from 1 up to 256.
// R3 - Channels 2 and 3 share one 8-bit divider whose field resets to 0x03.
// R4 - Bit 7 of the channel 2 control picks the first (0) or second (1) synthesizer for pair 2/3, reset 1.
// R5 - Channel 2 format in bits 6:5 picks off, AC differential, HCSL or LVCMOS, reset 0x1.
// R6 - Channel 3 format in bits 6:5 uses the same coding, reset 0x1, and its bit 7 is reserved.
// R7 - In LVCMOS mode1 in bits 4:3 drives the positive pin tristate, low, inverted or true, reset 0x2.
// R8 - In differential formats mode1 picks tail current 4, 6, 8 mA, or 16 mA for HCSL else 8 mA.
// R9 - In LVCMOS mode2 in bits 2:1 drives the negative pin with the same coding, reset 0x0.
// R10 - In HCSL mode2 picks the load: tristated, 50, 100 or 200 ohm.
// R11 - Reserved register bits ignore writes and read back as zero.
module clkout_cfg
  import clkout_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic             first_synth_clk,
  input  wire logic             second_synth_clk,
  input  wire logic             pair01_source_select,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [DAT_W-1:0] wb_dat_i,
  output logic      [DAT_W-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  pair01_div_clk,
  output logic                  ch2_p,
  output logic                  ch2_p_oe,
  output logic                  ch2_n,
  output logic                  ch2_n_oe,
  output logic      [4:0]       ch2_tail_ma,
  output logic      [7:0]       ch2_load_ohm,
  output logic                  ch3_p,
  output logic                  ch3_p_oe,
  output logic                  ch3_n,
  output logic                  ch3_n_oe,
  output logic      [4:0]       ch3_tail_ma,
  output logic      [7:0]       ch3_load_ohm
);

  typedef struct packed {
    logic [1:0] first_sync;
    logic [1:0] second_sync;
    logic [7:0] div01;
    logic [7:0] div23;
    logic       pair23_source_select;
    logic [1:0] ch2_format;
    logic [1:0] ch2_drive_mode_a;
    logic [1:0] ch2_drive_mode_b;
    logic [1:0] ch3_format;
    logic [1:0] ch3_drive_mode_a;
    logic [1:0] ch3_drive_mode_b;
    logic       ack;
    logic [7:0] rdata;
    drv_t       drv2;
    drv_t       drv3;
  } state_t;

  localparam state_t RST_STATE = '{
    first_sync:           2'h0,
    second_sync:          2'h0,
    div01:                RST_DIV01,
    div23:                RST_DIV23,
    pair23_source_select: RST_SRC23,
    ch2_format:           RST_FMT,
    ch2_drive_mode_a:     RST_MODE_A,
    ch2_drive_mode_b:     RST_MODE_B,
    ch3_format:           RST_FMT,
    ch3_drive_mode_a:     RST_MODE_A,
    ch3_drive_mode_b:     RST_MODE_B,
    ack:                  1'h0,
    rdata:                8'h00,
    drv2:                 '0,
    drv3:                 '0
  };

  state_t           q;
  state_t           d;
  logic             req;
  logic             wr_now;
  logic [IDX_W-1:0] idx;
  logic [7:0]       wbyte;
  logic             first_lvl;
  logic             second_lvl;
  logic             src01_lvl;
  logic             src23_lvl;
  logic             clk01;
  logic             clk23;

  // driver state of one channel from its format and modes
  function automatic drv_t drive(input logic [1:0] fmt,
                                 input logic [1:0] ma,
                                 input logic [1:0] mb,
                                 input logic       clk);
    drv_t r;
    r = '0;
    unique case (fmt)
      FMT_OFF: begin
        r = '0; // [R5]
      end
      FMT_LVCMOS: begin
        // each pin on its own mode code
        r.p_oe = (ma != PIN_TRI); // [R7]
        r.p    = (ma == PIN_TRUE) ? clk : ((ma == PIN_INV) ? ~clk : 1'b0); // [R7]
        r.n_oe = (mb != PIN_TRI); // [R9]
        r.n    = (mb == PIN_TRUE) ? clk : ((mb == PIN_INV) ? ~clk : 1'b0); // [R9]
      end
      FMT_ACDIFF, FMT_HCSL: begin
        r.p    = clk;
        r.p_oe = 1'b1;
        r.n    = ~clk;
        r.n_oe = 1'b1;
        unique case (ma)
          2'h0:    r.tail_ma = TAIL_4MA; // [R8]
          2'h1:    r.tail_ma = TAIL_6MA; // [R8]
          2'h2:    r.tail_ma = TAIL_8MA; // [R8]
          2'h3:    r.tail_ma = (fmt == FMT_HCSL) ? TAIL_16MA : TAIL_8MA; // [R8]
        endcase
        if (fmt == FMT_HCSL) begin
          unique case (mb)
            2'h0:  r.load_ohm = LOAD_TRI; // [R10]
            2'h1:  r.load_ohm = LOAD_50; // [R10]
            2'h2:  r.load_ohm = LOAD_100; // [R10]
            2'h3:  r.load_ohm = LOAD_200; // [R10]
          endcase
        end
      end
    endcase
    return r;
  endfunction

  // synchronised synthesizer levels and source muxes
  assign first_lvl  = q.first_sync[1];
  assign second_lvl = q.second_sync[1];
  assign src01_lvl  = pair01_source_select ? second_lvl : first_lvl;
  assign src23_lvl  = q.pair23_source_select ? second_lvl : first_lvl; // [R4]

  // shared divider for channels 0 and 1
  clk_out_divider u_div01 (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .src_level (src01_lvl),
    .div_field (q.div01), // [R1]
    .div_clk   (clk01)
  );

  // shared divider for channels 2 and 3
  clk_out_divider u_div23 (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .src_level (src23_lvl),
    .div_field (q.div23), // [R3]
    .div_clk   (clk23)
  );

  // bus decode, write takes effect at the edge that sees ack high
  assign req    = wb_cyc_i & wb_stb_i;
  assign wr_now = req & wb_we_i & q.ack & wb_sel_i[0];
  assign idx    = wb_adr_i[ADR_W-1:2];
  assign wbyte  = wb_dat_i[7:0];

  // next state
  always_comb begin
    d = q;
    d.first_sync  = {q.first_sync[0], first_synth_clk};
    d.second_sync = {q.second_sync[0], second_synth_clk};
    d.ack         = req & ~q.ack;
    // register writes; unmapped indices are acknowledged and dropped
    if (wr_now) begin
      unique case (idx)
        IDX_DIV01: begin
          d.div01 = wbyte; // [R1]
        end
        IDX_CTL2: begin
          d.pair23_source_select = wbyte[SRC_BIT]; // [R4]
          d.ch2_format           = wbyte[FMT_HI:FMT_LO]; // [R5]
          d.ch2_drive_mode_a     = wbyte[MA_HI:MA_LO]; // [R7]
          d.ch2_drive_mode_b     = wbyte[MB_HI:MB_LO]; // [R9]
        end
        IDX_CTL3: begin
          d.ch3_format           = wbyte[FMT_HI:FMT_LO]; // [R6]
          d.ch3_drive_mode_a     = wbyte[MA_HI:MA_LO]; // [R7]
          d.ch3_drive_mode_b     = wbyte[MB_HI:MB_LO]; // [R9]
        end
        IDX_DIV23: begin
          d.div23 = wbyte; // [R3]
        end
        default: begin
          d.div01 = q.div01;
        end
      endcase
    end
    // read data captured with the ack, reserved bits zero
    d.rdata = 8'h00;
    if (req & ~q.ack) begin
      unique case (idx)
        IDX_DIV01: d.rdata = q.div01;
        IDX_CTL2:  d.rdata = {q.pair23_source_select, q.ch2_format,
                              q.ch2_drive_mode_a, q.ch2_drive_mode_b, 1'b0}; // [R11]
        IDX_CTL3:  d.rdata = {1'b0, q.ch3_format,
                              q.ch3_drive_mode_a, q.ch3_drive_mode_b, 1'b0}; // [R11]
        IDX_DIV23: d.rdata = q.div23;
        default:   d.rdata = 8'h00;
      endcase
    end
    // channel drivers from the divided pair 2/3 clock
    d.drv2 = drive(q.ch2_format, q.ch2_drive_mode_a, q.ch2_drive_mode_b, clk23);
    d.drv3 = drive(q.ch3_format, q.ch3_drive_mode_a, q.ch3_drive_mode_b, clk23);
  end

  // single state register, frozen while ce is low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RST_STATE;
    end else if (ce) begin
      q <= d;
    end
  end

  // outputs
  assign wb_dat_o       = {{(DAT_W-8){1'b0}}, q.rdata};
  assign wb_ack_o       = q.ack;
  assign pair01_div_clk = clk01;
  assign ch2_p          = q.drv2.p;
  assign ch2_p_oe       = q.drv2.p_oe;
  assign ch2_n          = q.drv2.n;
  assign ch2_n_oe       = q.drv2.n_oe;
  assign ch2_tail_ma    = q.drv2.tail_ma;
  assign ch2_load_ohm   = q.drv2.load_ohm;
  assign ch3_p          = q.drv3.p;
  assign ch3_p_oe       = q.drv3.p_oe;
  assign ch3_n          = q.drv3.n;
  assign ch3_n_oe       = q.drv3.n_oe;
  assign ch3_tail_ma    = q.drv3.tail_ma;
  assign ch3_load_ohm   = q.drv3.load_ohm;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // bus handshake
  AST_ACK_PULSE: assert property (ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  AST_ACK_LATENCY: assert property (ce && req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");

  // divider fields hold unless written
  AST_DIV01_HOLD: assert property ( // [R1]
    ce && !(wr_now && idx == IDX_DIV01) |=> $stable(q.div01))
    else $error("pair 0/1 divider changed without a write");
  AST_DIV23_WRITE: assert property ( // [R3]
    ce && wr_now && idx == IDX_DIV23 |=> q.div23 == $past(wbyte))
    else $error("pair 2/3 divider write lost");

  // a zero written to the select bit moves pair 2/3 to the first synthesizer
  AST_SRC23: assert property ( // [R4]
    ce && wr_now && idx == IDX_CTL2 && !wbyte[SRC_BIT] |=> !q.pair23_source_select)
    else $error("pair 2/3 source select write lost");

  // format and pin behaviour
  AST_CH2_OFF: assert property (ce && q.ch2_format == FMT_OFF |=> !ch2_p_oe && !ch2_n_oe) // [R5]
    else $error("disabled channel 2 still drives");
  AST_CH3_OFF: assert property (ce && q.ch3_format == FMT_OFF |=> !ch3_p_oe && !ch3_n_oe) // [R6]
    else $error("disabled channel 3 still drives");
  AST_CMOS_LOW: assert property ( // [R7]
    ce && q.ch2_format == FMT_LVCMOS && q.ch2_drive_mode_a == PIN_LOW
    |=> ch2_p_oe && !ch2_p)
    else $error("channel 2 positive pin not held low");
  AST_CMOS_TRUE: assert property ( // [R7]
    ce && q.ch3_format == FMT_LVCMOS && q.ch3_drive_mode_a == PIN_TRUE
    |=> ch3_p == $past(clk23))
    else $error("channel 3 positive pin not true polarity");
  AST_TAIL_HCSL: assert property ( // [R8]
    ce && q.ch2_format == FMT_HCSL && q.ch2_drive_mode_a == 2'h3
    |=> ch2_tail_ma == TAIL_16MA)
    else $error("hcsl tail current not 16 mA");
  AST_TAIL_AC: assert property ( // [R8]
    ce && q.ch3_format == FMT_ACDIFF && q.ch3_drive_mode_a == 2'h3
    |=> ch3_tail_ma == TAIL_8MA)
    else $error("ac tail current not 8 mA");
  AST_CMOS_NTRI: assert property ( // [R9]
    ce && q.ch2_format == FMT_LVCMOS && q.ch2_drive_mode_b == PIN_TRI
    |=> !ch2_n_oe)
    else $error("channel 2 negative pin not tristated");
  AST_LOAD: assert property ( // [R10]
    ce && q.ch3_format == FMT_HCSL && q.ch3_drive_mode_b == 2'h2
    |=> ch3_load_ohm == LOAD_100)
    else $error("hcsl load not 100 ohm");
  AST_RSVD: assert property ( // [R11]
    ce && req && !wb_ack_o && idx == IDX_CTL3
    |=> wb_dat_o[7] == 1'b0 && wb_dat_o[0] == 1'b0)
    else $error("reserved bits read nonzero");

  // write paths of the remaining fields
  AST_DIV01_WRITE: assert property ( // [R1]
    ce && wr_now && idx == IDX_DIV01 |=> q.div01 == $past(wbyte))
    else $error("pair 0/1 divider write lost");
  AST_DIV23_HOLD: assert property ( // [R3]
    ce && !(wr_now && idx == IDX_DIV23) |=> $stable(q.div23))
    else $error("pair 2/3 divider changed without a write");
  AST_SRC23_SET: assert property ( // [R4]
    ce && wr_now && idx == IDX_CTL2 && wbyte[SRC_BIT] |=> q.pair23_source_select)
    else $error("pair 2/3 source select not set");
  AST_CTL3_OFF: assert property ( // [R6]
    ce && wr_now && idx == IDX_CTL3 && wbyte[FMT_HI:FMT_LO] == FMT_OFF
    |=> q.ch3_format == FMT_OFF)
    else $error("channel 3 format write lost");

  // differential pair, single-ended pins and unused settings
  AST_DIFF_PAIR: assert property ( // [R5]
    ce && q.ch2_format == FMT_ACDIFF |=> ch2_p_oe && ch2_n_oe && (ch2_n == !ch2_p))
    else $error("channel 2 differential pair not complementary");
  AST_CMOS_INV: assert property ( // [R7]
    ce && q.ch2_format == FMT_LVCMOS && q.ch2_drive_mode_a == PIN_INV
    |=> ch2_p == !$past(clk23))
    else $error("channel 2 positive pin not inverted");
  AST_CMOS_NTRUE: assert property ( // [R9]
    ce && q.ch2_format == FMT_LVCMOS && q.ch2_drive_mode_b == PIN_TRUE
    |=> ch2_n == $past(clk23))
    else $error("channel 2 negative pin not true polarity");
  AST_CMOS_NLOW: assert property ( // [R9]
    ce && q.ch3_format == FMT_LVCMOS && q.ch3_drive_mode_b == PIN_LOW
    |=> ch3_n_oe && !ch3_n)
    else $error("channel 3 negative pin not held low");
  AST_TAIL_CMOS: assert property ( // [R8]
    ce && q.ch2_format == FMT_LVCMOS |=> ch2_tail_ma == 5'h00)
    else $error("single-ended channel 2 shows a tail current");
  AST_LOAD_AC: assert property ( // [R10]
    ce && q.ch3_format == FMT_ACDIFF |=> ch3_load_ohm == 8'h00)
    else $error("ac channel 3 shows a load setting");
  AST_RSVD_CTL2: assert property ( // [R11]
    ce && req && !wb_ack_o && idx == IDX_CTL2 |=> wb_dat_o[0] == 1'b0)
    else $error("channel 2 reserved bit read nonzero");

  COV_WRITE_DIV23: cover property (wr_now && idx == IDX_DIV23);
  COV_CMOS_CH2: cover property (q.ch2_format == FMT_LVCMOS && ch2_p_oe);
  COV_SRC_FIRST: cover property (!q.pair23_source_select && clk23);
  COV_HCSL_LOAD: cover property (q.ch3_format == FMT_HCSL && ch3_load_ohm == LOAD_200);
  COV_DIV01_BYPASS: cover property (q.div01 == 8'h00 && clk01);

endmodule // clkout_cfg

// ### test/clk_sink_meter.sv
`timescale 1ns/1ps

// receiving end of one output clock: rise-to-rise spacing in ref_clk cycles
module clk_sink_meter (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        line,
  output logic      [15:0] period_q
);
  logic        line_q;
  logic [15:0] count_q;

  // edge detect and spacing counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_q   <= 1'b0;
      count_q  <= 16'h0000;
      period_q <= 16'h0000;
    end else begin
      line_q <= line;
      if (line && !line_q) begin
        period_q <= count_q;
        count_q  <= 16'h0001;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end
endmodule // clk_sink_meter

// ### test/clkout_cfg_tb.sv
`timescale 1ns/1ps

module clkout_cfg_tb
  import clkout_pkg::*;
;
  logic        ref_clk, arst_n, ce, s1_clk, s2_clk, sel01;
  logic        cyc, stb, we, ack, p01;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o;
  logic        c2p, c2po, c2n, c2no, c3p, c3po, c3n, c3no;
  logic [4:0]  c2t, c3t;
  logic [7:0]  c2l, c3l;
  logic [15:0] per01, per23;
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // ordinary cases: control byte, then p_oe, n_oe, tail, load
  logic [22:0] rows [0:11] = '{
    {8'h90, 2'b00, 5'h00, 8'h00}, {8'ha0, 2'b11, 5'h04, 8'h00},
    {8'ha8, 2'b11, 5'h06, 8'h00}, {8'hb0, 2'b11, 5'h08, 8'h00},
    {8'hbc, 2'b11, 5'h08, 8'h00}, {8'hd8, 2'b11, 5'h10, 8'h00},
    {8'hc2, 2'b11, 5'h04, 8'h32}, {8'hcc, 2'b11, 5'h06, 8'h64},
    {8'hd6, 2'b11, 5'h08, 8'hc8}, {8'he2, 2'b01, 5'h00, 8'h00},
    {8'he8, 2'b10, 5'h00, 8'h00}, {8'hfc, 2'b11, 5'h00, 8'h00}};
  // lvcmos pin pairs: byte, samples with p equal n, pin running
  logic [7:0]  pol_b [0:2] = '{8'h76, 8'h7e, 8'h6a};
  int          pol_same [0:2] = '{0, 24, 24};
  logic        pol_run [0:2] = '{1'b1, 1'b1, 1'b0};

  clkout_cfg u_clkout_cfg (
    .ref_clk(ref_clk), .arst_n(arst_n), .ce(ce), .first_synth_clk(s1_clk),
    .second_synth_clk(s2_clk), .pair01_source_select(sel01), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pair01_div_clk(p01), .ch2_p(c2p),
    .ch2_p_oe(c2po), .ch2_n(c2n), .ch2_n_oe(c2no), .ch2_tail_ma(c2t),
    .ch2_load_ohm(c2l), .ch3_p(c3p), .ch3_p_oe(c3po), .ch3_n(c3n),
    .ch3_n_oe(c3no), .ch3_tail_ma(c3t), .ch3_load_ohm(c3l));
  clk_sink_meter u_clk_sink_meter_01 (.ref_clk(ref_clk), .arst_n(arst_n), .line(p01),
                                      .period_q(per01));
  clk_sink_meter u_clk_sink_meter_23 (.ref_clk(ref_clk), .arst_n(arst_n), .line(c2p),
                                      .period_q(per23));

  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // synth stand-ins of 4 and 6 cycles, hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    s1_clk <= (cycles % 4) < 2;
    s2_clk <= (cycles % 6) < 3;
    if (cycles == 10000) begin
      fails++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle, held until ack is seen high
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= d;
    sel  <= 4'hf;
    // no limit of its own; the wait ends on ack, or at the bench timeout if ack never comes
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc  <= 1'b0;
    stb  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h000000, d});
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 32'h00000000);
    chk_reg(rdat, {24'h000000, exp});
  endtask

  // let three periods of the slower pair plus 20 cycles pass, then compare both meters
  task automatic periods(input int e01, input int e23);
    repeat (3 * ((e01 > e23) ? e01 : e23) + 20) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_out({16'h0000, per01}, e01, "pair01 period");
    chk_out({16'h0000, per23}, e23, "pair23 period");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    int i;
    int same;
    int hi;
    arst_n = 1'b0;
    ce = 1'b1;
    sel01 = 1'b0;
    {cyc, stb, we, adr, sel, wdat} = '0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(IDX_DIV01, 8'h01);
    rd(IDX_CTL2, 8'hb0);
    rd(IDX_CTL3, 8'h30);
    rd(IDX_DIV23, 8'h03);
    chk_out({c2po, c2no, c2t, c3t}, {20'h0, 2'b11, 5'h08, 5'h08}, "reset drive");
    periods(8, 24);
    $display("test reset values done");
    wr(IDX_DIV01, 8'h00);
    periods(4, 24);
    wr(IDX_DIV01, 8'hff);
    periods(1024, 24);
    @(posedge ref_clk);
    sel01 <= 1'b1;
    wr(IDX_DIV01, 8'h01);
    wr(IDX_CTL2, 8'h20);
    periods(12, 16);
    wr(IDX_DIV23, 8'h00);
    periods(12, 4);
    $display("test dividers done");
    // clock enable low freezes the running pair 2/3 pin
    @(posedge ref_clk);
    ce <= 1'b0;
    @(negedge ref_clk);
    hi = c2p;
    repeat (12) @(negedge ref_clk);
    chk_out(c2p, hi, "frozen pin");
    @(posedge ref_clk);
    ce <= 1'b1;
    $display("test clock enable done");
    for (i = 0; i < 12; i++) begin
      wr(IDX_CTL2, rows[i][22:15]);
      wr(IDX_CTL3, rows[i][22:15]);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk_out({c2po, c2no, c2t, c2l}, rows[i][14:0], "ch2 drive");
      chk_out({c3po, c3no, c3t, c3l}, rows[i][14:0], "ch3 drive");
      rd(IDX_CTL2, rows[i][22:15] & 8'hfe);
      rd(IDX_CTL3, rows[i][22:15] & 8'h7e);
    end
    $display("test format table done");
    for (i = 0; i < 3; i++) begin
      wr(IDX_CTL2, pol_b[i]);
      repeat (4) @(posedge ref_clk);
      same = 0;
      hi = 0;
      repeat (24) begin
        @(negedge ref_clk);
        same += (c2p === c2n);
        hi += (c2p === 1'b1);
      end
      chk_out(same, pol_same[i], "pin relation");
      chk_out(hi != 0, pol_run[i], "pin activity");
    end
    $display("test lvcmos pins done");
    wr(IDX_CTL2, 8'hff);
    rd(IDX_CTL2, 8'hfe);
    wr(IDX_CTL3, 8'hff);
    rd(IDX_CTL3, 8'h7e);
    wr(6'h25, 8'h55);
    rd(6'h25, 8'h00);
    $display("test reserved and unmapped done");
    wr(IDX_DIV23, 8'h10);
    rd(IDX_DIV23, 8'h10);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(IDX_DIV23, 8'h03);
    rd(IDX_CTL2, 8'hb0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // clkout_cfg_tb
